//--- hw/dsp_port.sv
// Purpose: Slave port serving register access over I2C or SPI
// Assumes: Register file answers rd_data in the cycle after rd_stb
// Notes:   Pins sampled on ref_clk; bus clock must be under ~5 MHz
`timescale 1ns/1ns
`default_nettype none
module dsp_port
    import dsp_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic       cs_pin,
    input  wire logic       serial_port_clock,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    output logic            sdo_out,
    output logic            sdo_oe,
    input  wire logic       three_wire_select,
    output dsp_reg_req_t    reg_req,
    input  wire logic [7:0] rd_data,
    output logic            bus_busy
);
    typedef enum logic [3:0] {
        S_IDLE, S_I_ADDR, S_I_AACK, S_I_INDEX, S_I_WDATA, S_I_ACK,
        S_I_RDATA, S_I_MACK, S_I_IGNORE, S_S_HDR, S_S_DATA
    } dsp_state_t;

    typedef struct packed {
        dsp_state_t   state;
        logic         rnw;
        logic         inc;
        logic [6:0]   index;
        logic         busy;
        logic         sda_drv;     // Drives low when set
        logic         sdo_val;
        logic         sda_oe;
        logic         sdo_oe;
        logic         pend_load;   // Read data arrives next cycle
        logic         first;
        dsp_reg_req_t req;
    } dsp_st_t;

    dsp_st_t   st_r;
    dsp_st_t   st_nxt;
    dsp_pins_t pins;

    logic       sh_clear;
    logic       sh_sample;
    logic       sh_load;
    logic [7:0] sh_data;
    logic [3:0] sh_count;
    logic       sh_done;

    // three-flop sampling keeps up with standard and fast clocks
    dsp_pin_sync u_sync (
        .ref_clk (ref_clk),
        .reset   (reset),
        .cs_pin  (cs_pin),
        .scl_pin (serial_port_clock),
        .sda_pin (sda_in),
        .pins    (pins)
    );

    // Master data is sampled on rising clock in both protocols
    dsp_shift8 u_shift (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .clear    (sh_clear),
        .sample   (sh_sample),
        .bit_in   (pins.sda),
        .load     (sh_load),
        .load_val (rd_data),
        .data     (sh_data),
        .count    (sh_count),
        .done     (sh_done)
    );

    function automatic logic [6:0] next_index(input logic [6:0] idx, input logic inc, input logic spi);
        logic [6:0] n;
        n = idx + 7'h1;
        if (!inc) begin
            n = idx;
        end else if (spi) begin
            n = {1'b0, n[5:0]};            // Six-bit SPI index wraps
        end
        return n;
    endfunction

    logic i2c_start;
    logic i2c_stop;
    assign i2c_start = pins.cs & pins.scl & pins.sda_fall;
    assign i2c_stop  = pins.cs & pins.scl & pins.sda_rise;

    assign sh_load = st_r.pend_load;

    // Main sequencer
    always_comb begin
        st_nxt           = st_r;
        st_nxt.req.wr_stb = 1'b0;
        st_nxt.req.rd_stb = 1'b0;
        st_nxt.pend_load = st_r.req.rd_stb;
        sh_clear         = 1'b0;
        sh_sample        = 1'b0;
        // protocol select by chip select level
        // frame bit count restarts at select fall
        if (pins.cs_fall) begin
            st_nxt.state   = S_S_HDR;
            st_nxt.sda_drv = 1'b0;
            st_nxt.sda_oe  = 1'b0;
            st_nxt.busy    = 1'b1;
            sh_clear       = 1'b1;
        end else if (pins.cs_rise) begin
            // release pads at end of frame
            st_nxt.state  = S_IDLE;
            st_nxt.sdo_oe  = 1'b0;
            st_nxt.sda_oe  = 1'b0;
            st_nxt.sda_drv = 1'b0;        // Else I2C idle would see a stale low drive
            st_nxt.busy    = 1'b0;
            sh_clear       = 1'b1;
        end else if (i2c_start) begin
            st_nxt.state   = S_I_ADDR;
            st_nxt.busy    = 1'b1;
            st_nxt.sda_drv = 1'b0;
            sh_clear       = 1'b1;
        end else if (i2c_stop) begin
            st_nxt.state   = S_IDLE;
            st_nxt.busy    = 1'b0;
            st_nxt.sda_drv = 1'b0;
            sh_clear       = 1'b1;
        end else begin
            case (st_r.state)
                S_I_ADDR: begin
                    sh_sample = pins.scl_rise;
                    if (sh_done) begin
                        st_nxt.rnw = pins.sda;     // Direction is the eighth bit, still on the pin
                        if (sh_data[6:0] == DSP_BUS_SLAVE_ID) begin
                            st_nxt.state = S_I_AACK;
                            if (pins.sda) begin
                                st_nxt.req.rd_stb = 1'b1;   // fetch for read
                                st_nxt.req.addr   = st_r.index;
                            end
                        end else begin
                            st_nxt.state = S_I_IGNORE;
                        end
                    end
                end
                S_I_AACK: begin
                    if (pins.scl_fall) begin
                        if (!st_r.sda_drv) begin
                            st_nxt.sda_drv = 1'b1;
                        end else begin
                            st_nxt.sda_drv = 1'b0;
                            st_nxt.first   = 1'b1;
                            st_nxt.state   = st_r.rnw ? S_I_RDATA : S_I_INDEX;
                            if (st_r.rnw) begin
                                st_nxt.sda_drv = ~sh_data[7];
                            end
                        end
                    end
                end
                S_I_INDEX: begin
                    sh_sample = pins.scl_rise;
                    if (sh_done) begin
                        st_nxt.index = {sh_data[5:0], pins.sda};
                        st_nxt.inc   = sh_data[DSP_INC_BIT - 1];
                        st_nxt.state = S_I_ACK;
                    end
                end
                S_I_WDATA: begin
                    sh_sample = pins.scl_rise;
                    if (sh_done) begin
                        st_nxt.req.wr_stb = 1'b1;
                        st_nxt.req.addr   = st_r.index;
                        st_nxt.req.wdata  = {sh_data[6:0], pins.sda};
                        st_nxt.index      = next_index(st_r.index, st_r.inc, 1'b0);
                        st_nxt.state      = S_I_ACK;
                    end
                end
                // no stall needed; bytes handled within a bit time
                S_I_ACK: begin
                    if (pins.scl_fall) begin
                        st_nxt.sda_drv = ~st_r.sda_drv;
                        if (st_r.sda_drv) begin
                            st_nxt.state = S_I_WDATA;
                        end
                    end
                end
                // read byte out MSb first, bit changes on falling clock
                S_I_RDATA: begin
                    sh_sample = pins.scl_rise;
                    if (pins.scl_fall) begin
                        st_nxt.sda_drv = ~sh_data[7];
                        if (sh_count == 4'h0 && !st_r.first) begin
                            st_nxt.sda_drv = 1'b0;           // Release for master ack
                            st_nxt.state   = S_I_MACK;
                            st_nxt.index   = next_index(st_r.index, st_r.inc, 1'b0);
                        end
                    end
                    if (pins.scl_rise) begin
                        st_nxt.first = 1'b0;
                    end
                end
                S_I_MACK: begin
                    if (pins.scl_rise) begin
                        if (pins.sda) begin
                            st_nxt.state = S_I_IGNORE;
                        end else begin
                            st_nxt.req.rd_stb = 1'b1;
                            st_nxt.req.addr   = st_r.index;
                        end
                    end
                    if (pins.scl_fall && st_r.state == S_I_MACK && !pins.scl) begin
                        st_nxt.state   = S_I_RDATA;
                        st_nxt.first   = 1'b1;
                        st_nxt.sda_drv = ~sh_data[7];
                    end
                end
                S_S_HDR: begin
                    sh_sample = pins.scl_rise;
                    if (sh_done) begin
                        st_nxt.rnw   = sh_data[6];
                        st_nxt.inc   = sh_data[5];
                        st_nxt.index = {1'b0, sh_data[4:0], pins.sda};
                        st_nxt.state = S_S_DATA;
                        if (sh_data[6]) begin
                            st_nxt.req.rd_stb = 1'b1;
                            st_nxt.req.addr   = {1'b0, sh_data[4:0], pins.sda};
                        end
                    end
                end
                // data bits; drive on falling edge
                S_S_DATA: begin
                    sh_sample = pins.scl_rise;
                    if (pins.scl_fall && st_r.rnw) begin
                        // drive from bit 8; pad choice
                        st_nxt.sdo_val = sh_data[7];
                        st_nxt.sdo_oe  = ~three_wire_select;
                        st_nxt.sda_oe  = three_wire_select;
                        st_nxt.sda_drv = ~sh_data[7];
                    end
                    if (sh_done) begin
                        if (!st_r.rnw) begin
                            st_nxt.req.wr_stb = 1'b1;
                            st_nxt.req.wdata  = {sh_data[6:0], pins.sda};
                            st_nxt.req.addr   = st_r.index;
                        end
                        st_nxt.index = next_index(st_r.index, st_r.inc, 1'b1);
                        if (st_r.rnw) begin
                            st_nxt.req.rd_stb = 1'b1;
                            st_nxt.req.addr   = next_index(st_r.index, st_r.inc, 1'b1);
                        end
                    end
                end
                default: begin
                    st_nxt.sda_drv = 1'b0;
                end
            endcase
        end
        // I2C pad drives only low; SPI pad carries data
        if (pins.cs) begin
            st_nxt.sda_oe = st_nxt.sda_drv;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_r <= '{state: S_IDLE, req: '0, index: 7'h00, default: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // Pads; sda_out low in I2C, data in 3-wire SPI
    assign sda_out  = st_r.sdo_val & ~st_r.busy | (st_r.sdo_val & ~pins.cs);
    assign sdo_out  = st_r.sdo_val;
    assign sdo_oe   = st_r.sdo_oe;
    assign sda_oe   = st_r.sda_oe;
    assign reg_req  = st_r.req;
    assign bus_busy = st_r.busy;

    mismatch_quiet_a: assert property (@(posedge ref_clk) disable iff (reset)
        st_r.state == S_I_IGNORE && pins.cs |-> !sda_oe)
        else $error("pad driven while ignoring");
    // no drive outside frame in SPI
    spi_release_a: assert property (@(posedge ref_clk) disable iff (reset)
        pins.cs_rise |=> !sdo_oe)
        else $error("SPI pad held after select rose");
    write_quiet_a: assert property (@(posedge ref_clk) disable iff (reset)
        st_r.state == S_S_DATA && !st_r.rnw |-> !sdo_oe)
        else $error("output driven on write");
    start_seen_a: assert property (@(posedge ref_clk) disable iff (reset)
        i2c_start && !pins.cs_fall && !pins.cs_rise |=> st_r.state == S_I_ADDR && bus_busy)
        else $error("start not taken");
    stop_seen_a: assert property (@(posedge ref_clk) disable iff (reset)
        i2c_stop && !i2c_start && !pins.cs_rise |=> !bus_busy)
        else $error("stop not taken");
    mode_pad_a: assert property (@(posedge ref_clk) disable iff (reset)
        sdo_oe |-> !three_wire_select || $past(!three_wire_select))
        else $error("four-wire pad used in three-wire mode");
    sequence hdr_done_s;
        st_r.state == S_S_HDR ##1 st_r.state == S_S_DATA;
    endsequence
    hdr_len_a: assert property (@(posedge ref_clk) disable iff (reset)
        hdr_done_s |-> $past(sh_count, 2) == 4'h7)
        else $error("header not eight bits");
    // write strobe only from data phase
    wr_source_a: assert property (@(posedge ref_clk) disable iff (reset)
        reg_req.wr_stb |-> $past(st_r.state) inside {S_S_DATA, S_I_WDATA})
        else $error("stray write strobe");
endmodule // dsp_port
`default_nettype wire

//--- hw/dsp_pkg.sv
// Purpose: Shared constants and types for the dual serial register port
// Assumes: ref_clk at 50 MHz, bus pins sampled through two flip-flops
// Notes:   Behaviour
// Behaviour
// - Chip select high picks I2C, low SPI
// - SDA falling while SCL high is start
// - First byte: seven-bit id plus direction
// - Receiver pulls data low during acknowledge
// - Index byte: low seven bits, top increments
// - Read continues on ack, ends on no-ack
// - Bytes are eight bits, MSb first
// - Receiver may hold clock low to stall; this port has no clock output and never stalls
// - Works at standard and fast clock rates
// - Data changes on falling, sampled rising
// - Sixteen clocks per register, eight per extra
// - Bit 0 at first falling edge after select
// - Bit 0 direction; read drives from bit 8
// - Bit 1 selects index auto-increment
// - Bits 2 to 7 are register index
// - Bits 8 to 15 carry data byte
// - Three-wire mode returns data on shared pad
// - Mode bit clear four-wire, set three-wire
package dsp_pkg;
    localparam logic [6:0] DSP_BUS_SLAVE_ID = 7'h1d;   // 0011101b
    localparam logic [3:0] DSP_SPI_HDR_BITS = 4'h8;
    localparam logic [3:0] DSP_BYTE_BITS    = 4'h8;
    localparam int         DSP_INC_BIT      = 7;       // Top of I2C index byte

    // Bus side of the register file: one strobe carries one byte
    typedef struct packed {
        logic       wr_stb;
        logic       rd_stb;
        logic [6:0] addr;
        logic [7:0] wdata;
    } dsp_reg_req_t;

    // Synchronised pin levels and their edges
    typedef struct packed {
        logic cs;
        logic scl;
        logic sda;
        logic scl_rise;
        logic scl_fall;
        logic sda_rise;
        logic sda_fall;
        logic cs_rise;
        logic cs_fall;
    } dsp_pins_t;
endpackage

//--- hw/dsp_pin_sync.sv
// Purpose: Two-flop synchroniser and edge finder for the bus pins
// Assumes: Pins are asynchronous to ref_clk
// Notes:   Edge detection reads only the second and third stages
`timescale 1ns/1ns
`default_nettype none
module dsp_pin_sync
    import dsp_pkg::*;
(
    input  wire logic      ref_clk,
    input  wire logic      reset,
    input  wire logic      cs_pin,
    input  wire logic      scl_pin,
    input  wire logic      sda_pin,
    output dsp_pins_t      pins
);
    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        logic [2:0] s3;
    } dsp_sync_t;

    dsp_sync_t st_r;
    dsp_sync_t st_nxt;

    // Shift pins through stages; idle bus reads high
    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = {cs_pin, scl_pin, sda_pin};
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_r <= '{s1: 3'h7, s2: 3'h7, s3: 3'h7};
        end else begin
            st_r <= st_nxt;
        end
    end

    // Edges compare settled stages only
    always_comb begin
        pins.cs       = st_r.s2[2];
        pins.scl      = st_r.s2[1];
        pins.sda      = st_r.s2[0];
        pins.cs_rise  = st_r.s2[2] & ~st_r.s3[2];
        pins.cs_fall  = ~st_r.s2[2] & st_r.s3[2];
        pins.scl_rise = st_r.s2[1] & ~st_r.s3[1];
        pins.scl_fall = ~st_r.s2[1] & st_r.s3[1];
        pins.sda_rise = st_r.s2[0] & ~st_r.s3[0];
        pins.sda_fall = ~st_r.s2[0] & st_r.s3[0];
    end
endmodule // dsp_pin_sync
`default_nettype wire

//--- hw/dsp_shift8.sv
// Purpose: Eight-bit MSb-first shift register with bit counter
// Assumes: Sample and load strobes are one-cycle pulses
// Notes:   Load wins over shift; done pulses on the eighth sample
`timescale 1ns/1ns
`default_nettype none
module dsp_shift8
    import dsp_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic       clear,
    input  wire logic       sample,
    input  wire logic       bit_in,
    input  wire logic       load,
    input  wire logic [7:0] load_val,
    output logic      [7:0] data,
    output logic      [3:0] count,
    output logic            done
);
    typedef struct packed {
        logic [7:0] sh;
        logic [3:0] cnt;
    } dsp_sh_t;

    dsp_sh_t st_r;
    dsp_sh_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (clear) begin
            st_nxt.cnt = 4'h0;
        end else if (sample) begin
            st_nxt.sh  = {st_r.sh[6:0], bit_in};
            st_nxt.cnt = (st_r.cnt == DSP_BYTE_BITS - 4'h1) ? 4'h0 : st_r.cnt + 4'h1;
        end
        if (load) begin
            st_nxt.sh = load_val;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign data  = st_r.sh;
    assign count = st_r.cnt;
    assign done  = sample & ~clear & (st_r.cnt == DSP_BYTE_BITS - 4'h1);
endmodule // dsp_shift8
`default_nettype wire

//--- dv/dsp_master_model.sv
// Purpose: Bus master model driving the port over I2C or SPI
// Assumes: Shared pad has a pull-up; SDO floats when released
// Notes:   Timed by delays, so bus edges are unrelated to ref_clk
`timescale 1ns/1ns
`default_nettype none
module dsp_master_model
    import dsp_pkg::*;
(
    output logic      cs,
    output logic      scl,
    output logic      pad_oe,
    output logic      pad_val,
    input  wire logic sda_line,
    input  wire logic sdo_line,
    input  wire logic dev_drive
);
    int half_ns = 80;  // Half bus period
    int early   = 0;   // Device drove during header bits

    initial begin
        cs      = 1'b1;
        scl     = 1'b1;
        pad_oe  = 1'b0;
        pad_val = 1'b1;
    end

    task automatic spi_xfer(input logic [7:0] hdr, input int n, input logic [31:0] wdat,
                            input logic three_w, output logic [31:0] rdat);
        logic [39:0] sh;
        sh   = {hdr, wdat};
        rdat = '0;
        cs   = 1'b0;
        #(half_ns);
        for (int b = 0; b < 8 + 8 * n; b++) begin
            scl     = 1'b0;
            // Release the shared pad while the device answers a 3-wire read
            pad_oe  = !(hdr[7] && three_w && b >= 8);
            pad_val = sh[39 - b];
            #(half_ns);
            scl = 1'b1;
            if (b < 8 && dev_drive) early++;
            if (b >= 8) rdat = {rdat[30:0], three_w ? sda_line : sdo_line};
            #(half_ns);
        end
        cs     = 1'b1;
        pad_oe = 1'b0;
        #(4 * half_ns);
    endtask

    task automatic i2c_start();
        pad_oe  = 1'b0;
        pad_val = 1'b0;
        #(half_ns / 2);
        scl = 1'b1;
        #(half_ns / 2);
        pad_oe = 1'b1;
        #(half_ns / 2);
        scl = 1'b0;
        #(half_ns / 2);
    endtask

    task automatic i2c_stop();
        pad_oe = 1'b1;
        #(half_ns / 2);
        scl = 1'b1;
        #(half_ns / 2);
        pad_oe = 1'b0;
        #(half_ns);
    endtask

    task automatic i2c_bit(input logic drive_low, output logic seen);
        #(half_ns / 2);
        pad_oe = drive_low;
        #(half_ns / 2);
        scl = 1'b1;
        #(half_ns / 2);
        seen = sda_line;
        #(half_ns / 2);
        scl = 1'b0;
    endtask

    // send MSb first, release for acknowledge
    task automatic i2c_send(input logic [7:0] b, output logic ack_n);
        logic s;
        for (int i = 7; i >= 0; i--) i2c_bit(!b[i], s);
        i2c_bit(1'b0, ack_n);
    endtask

    // receive MSb first, then ack or withhold
    task automatic i2c_recv(input logic ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            i2c_bit(1'b0, s);
            b[i] = s;
        end
        i2c_bit(ack, s);
    endtask
endmodule // dsp_master_model
`default_nettype wire

//--- dv/test_dual_serial_register_port.sv
// Purpose: Self-checking bench for the dual serial register port
// Assumes: Register file stand-in answers one cycle after a read strobe
// Notes:   SPI frames come from a row table; I2C cases are hand-written
`timescale 1ns/1ns
`default_nettype none
`define CHK(what, exp, got) begin compares++; if ((got) !== (exp)) begin num_errors++; \
    $display("FAIL %s expected %h seen %h", what, exp, got); end end
module test_dual_serial_register_port import dsp_pkg::*;;
    typedef struct packed {
        logic        tw;
        logic        rd;
        logic        inc;
        logic  [5:0] addr;
        logic  [2:0] n;
        logic [31:0] wdat;
    } dsp_row_t;
    // Wrap-around bursts in four-wire mode, fixed-index bursts in both wire modes
    localparam dsp_row_t ROWS [8] = '{
        '{1'b0, 1'b0, 1'b0, 6'h20, 3'h1, 32'ha5000000},
        '{1'b0, 1'b0, 1'b1, 6'h3f, 3'h2, 32'h3cc30000},
        '{1'b0, 1'b0, 1'b0, 6'h15, 3'h2, 32'h5a690000},
        '{1'b0, 1'b1, 1'b0, 6'h0f, 3'h1, 32'h00000000},
        '{1'b0, 1'b1, 1'b1, 6'h3e, 3'h3, 32'h00000000},
        '{1'b1, 1'b1, 1'b0, 6'h21, 3'h2, 32'h00000000},
        '{1'b1, 1'b1, 1'b1, 6'h28, 3'h2, 32'h00000000},
        '{1'b1, 1'b0, 1'b1, 6'h22, 3'h2, 32'h0ff00000}};
    logic         ref_clk;
    logic         reset = 1'b1;
    logic         tw = 1'b0;
    logic   [7:0] rd_data = 8'h00;
    logic         cs;
    logic         scl;
    logic         pad_oe;
    logic         pad_val;
    logic         sda_out;
    logic         sda_oe;
    logic         sdo_out;
    logic         sdo_oe;
    logic         bus_busy;
    dsp_reg_req_t reg_req;
    wire logic    sda_line;
    wire logic    sdo_line;
    int           num_errors = 0;
    int           compares = 0;
    int           cycles = 0;
    logic  [14:0] wr_log[$];
    dsp_row_t     row;
    logic  [31:0] rdat;
    logic   [5:0] a;
    logic         ack_n;
    logic   [7:0] b;

    // Open-drain pad with pull-up; SDO floats when released
    assign sda_line = ~((pad_oe & ~pad_val) | (sda_oe & ~sda_out));
    assign sdo_line = sdo_oe ? sdo_out : 1'bz;

    dsp_port uut (.ref_clk(ref_clk), .reset(reset), .cs_pin(cs), .serial_port_clock(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
        .three_wire_select(tw), .reg_req(reg_req), .rd_data(rd_data), .bus_busy(bus_busy));
    dsp_master_model master (.cs(cs), .scl(scl), .pad_oe(pad_oe), .pad_val(pad_val),
        .sda_line(sda_line), .sdo_line(sdo_line), .dev_drive(sda_oe | sdo_oe));

    function automatic logic [7:0] reg_val(input logic [6:0] ad);
        return {ad, 1'b1} ^ 8'h96;
    endfunction

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // Register file stand-in; writes logged for later checks
    always @(posedge ref_clk) begin
        if (reg_req.rd_stb) rd_data <= reg_val(reg_req.addr);
        if (reg_req.wr_stb) wr_log.push_back({reg_req.addr, reg_req.wdata});
    end

    // Hang guard; the run needs roughly 31k cycles
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            num_errors++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (19) @(posedge ref_clk);
        `CHK("reset outputs", 20'h0, {reg_req, sda_oe, sdo_oe, bus_busy})
        @(posedge ref_clk);
        #2 reset = 1'b0;
        repeat (4) @(posedge ref_clk);
        $display("reset test done");
        // Row table of SPI frames
        for (int r = 0; r < 8; r++) begin
            row = ROWS[r];
            wr_log.delete();
            #2 tw = row.tw;
            repeat (4) @(posedge ref_clk);
            #2 master.spi_xfer({row.rd, row.inc, row.addr}, row.n, row.wdat, row.tw, rdat);
            repeat (6) @(posedge ref_clk);
            for (int k = 0; k < row.n; k++) begin
                a = row.inc ? row.addr + 6'(k) : row.addr;
                if (row.rd) begin
                    `CHK("spi read", reg_val({1'b0, a}), rdat[8 * (row.n - 1 - k) +: 8])
                end else begin
                    `CHK("spi write", {1'b0, a, row.wdat[31 - 8 * k -: 8]}, wr_log[k])
                end
            end
            if (!row.rd) `CHK("spi write count", 32'(row.n), wr_log.size())
            `CHK("pads released", 2'b00, {sda_oe, sdo_oe})
            $display("spi row %0d done", r);
        end
        `CHK("early drive", 0, master.early)
        // Fast-mode I2C write burst with auto-increment
        tw = 1'b0;
        master.half_ns = 1250;
        wr_log.delete();
        master.i2c_start();
        `CHK("busy after start", 1'b1, bus_busy)
        master.i2c_send({DSP_BUS_SLAVE_ID, 1'b0}, ack_n);
        `CHK("address ack", 1'b0, ack_n)
        master.i2c_send(8'h90, ack_n);
        `CHK("index ack", 1'b0, ack_n)
        master.i2c_send(8'h11, ack_n);
        master.i2c_send(8'h22, ack_n);
        `CHK("data ack", 1'b0, ack_n)
        master.i2c_stop();
        `CHK("idle after stop", 1'b0, bus_busy)
        `CHK("i2c write 0", {7'h10, 8'h11}, wr_log[0])
        `CHK("i2c write 1", {7'h11, 8'h22}, wr_log[1])
        $display("i2c write test done");
        // Read through repeated start, ack then no-ack
        master.i2c_start();
        master.i2c_send({DSP_BUS_SLAVE_ID, 1'b0}, ack_n);
        master.i2c_send(8'h85, ack_n);
        master.i2c_start();
        master.i2c_send({DSP_BUS_SLAVE_ID, 1'b1}, ack_n);
        `CHK("read address ack", 1'b0, ack_n)
        master.i2c_recv(1'b1, b);
        `CHK("i2c read 0", reg_val(7'h05), b)
        master.i2c_recv(1'b0, b);
        `CHK("i2c read 1", reg_val(7'h06), b)
        repeat (8) @(posedge ref_clk);
        `CHK("released after no-ack", 1'b0, sda_oe)
        master.i2c_stop();
        $display("i2c read test done");
        // Foreign address: no ack, bytes ignored
        wr_log.delete();
        master.i2c_start();
        master.i2c_send({DSP_BUS_SLAVE_ID ^ 7'h01, 1'b0}, ack_n);
        `CHK("foreign address ack", 1'b1, ack_n)
        master.i2c_send(8'h10, ack_n);
        master.i2c_send(8'hff, ack_n);
        `CHK("foreign data ack", 1'b1, ack_n)
        master.i2c_stop();
        `CHK("foreign writes", 0, wr_log.size())
        $display("i2c foreign address test done");
        // Standard-mode single write at the top index
        master.half_ns = 5000;
        master.i2c_start();
        master.i2c_send({DSP_BUS_SLAVE_ID, 1'b0}, ack_n);
        master.i2c_send(8'h7f, ack_n);
        master.i2c_send(8'h5a, ack_n);
        master.i2c_stop();
        `CHK("standard write", {7'h7f, 8'h5a}, wr_log[0])
        $display("i2c standard mode test done");
        wrap_up();
    end
endmodule // test_dual_serial_register_port
`undef CHK
`default_nettype wire
